//--- hw/stpd_power_ctrl.sv
// Powerdown controller top: level-valid flag, inactivity timer, force inputs, interrupts.
// Assumes force inputs and rxLevelValid synchronous to clock; txIn and rxIn pass through synchronisers.
`timescale 1ns/1ps
`default_nettype none
module stpd_power_ctrl #(
    parameter longint IDLE_CYCLES = stpd_pkg::IDLE_CYC,
    parameter int WAKE_CYCLES = stpd_pkg::WAKE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire stpd_pkg::stpd_line_t line,
    input wire logic hold_awake_in,
    input wire logic power_kill_n_in,
    input wire stpd_pkg::stpd_bus_t bus,
    output logic [31:0] rdata,
    output logic levelValid,
    output logic pumpOn,
    output logic txOe_b,
    output logic rxOe_b,
    output logic irq
);
    logic lineEdge;
    logic txEdge;
    logic rxEdge;
    logic [stpd_pkg::CNT_W+7:0] idle_r;
    logic [stpd_pkg::CNT_W+7:0] idle_nxt;
    logic expired;
    logic holdLast_r;
    logic holdRise;
    logic autoEn;
    logic wakeReq;
    logic [stpd_pkg::CNT_W-1:0] wake_r;
    logic [stpd_pkg::CNT_W-1:0] wake_nxt;
    stpd_pkg::stpd_state_t state_r;
    stpd_pkg::stpd_state_t state_nxt;
    logic validLast_r;
    logic [stpd_pkg::NUM_EVT-1:0] events;
    logic [stpd_pkg::NUM_EVT-1:0] status_r;
    logic [stpd_pkg::NUM_EVT-1:0] enable_r;
    logic [stpd_pkg::NUM_EVT-1:0] clearMask;
    logic [31:0] rdata_nxt;
    logic active;

    stpd_edge_det #(.W(stpd_pkg::NUM_TX)) u_tx_edge (
        .clock(clock),
        .rst_b(rst_b),
        .din(line.txIn),
        .anyEdge(txEdge)
    );
    stpd_edge_det #(.W(stpd_pkg::NUM_RX)) u_rx_edge (
        .clock(clock),
        .rst_b(rst_b),
        .din(line.rxIn),
        .anyEdge(rxEdge)
    );
    // The flag runs in every mode; nothing below reads it for power.
    stpd_level_det u_level (
        .clock(clock),
        .rst_b(rst_b),
        .rxLevelValid(line.rxLevelValid),
        .levelValid(levelValid)
    );

    assign lineEdge = txEdge | rxEdge;
    assign autoEn = !hold_awake_in && power_kill_n_in;
    assign holdRise = hold_awake_in && !holdLast_r;
    assign expired = (idle_r >= (stpd_pkg::CNT_W + 8)'(IDLE_CYCLES));

    // Idle timer restarts on activity or while hold-awake is high, so a falling
    // hold-awake leaves a full window. Once expired it holds until an input edge or hold-awake restarts it.
    assign idle_nxt = (lineEdge || hold_awake_in) ? '0 :
                      expired ? idle_r : idle_r + 1'b1;

    // Wake needs power-kill high and either hold-awake or an input edge.
    assign wakeReq = power_kill_n_in && (hold_awake_in || lineEdge);

    always_comb begin
        state_nxt = state_r;
        wake_nxt = '0;
        case (state_r)
            stpd_pkg::ST_ACTIVE: begin
                if (!power_kill_n_in) begin
                    state_nxt = stpd_pkg::ST_DOWN;
                end else if (autoEn && expired) begin
                    state_nxt = stpd_pkg::ST_DOWN;
                end
            end
            stpd_pkg::ST_DOWN: begin
                if (wakeReq) begin
                    state_nxt = stpd_pkg::ST_WAKING;
                end
            end
            stpd_pkg::ST_WAKING: begin
                wake_nxt = wake_r + 1'b1;
                if (!power_kill_n_in) begin
                    state_nxt = stpd_pkg::ST_DOWN;
                end else if (wake_r >= stpd_pkg::CNT_W'(WAKE_CYCLES - 1)) begin
                    state_nxt = stpd_pkg::ST_ACTIVE;
                end
            end
            default: begin
                state_nxt = stpd_pkg::ST_DOWN;
            end
        endcase
    end

    assign active = (state_r == stpd_pkg::ST_ACTIVE);
    assign events[stpd_pkg::EVT_POWER_DOWN] = active && (state_nxt == stpd_pkg::ST_DOWN);
    assign events[stpd_pkg::EVT_POWER_UP] = !active && (state_nxt == stpd_pkg::ST_ACTIVE);
    assign events[stpd_pkg::EVT_VALID_CHG] = levelValid != validLast_r;
    assign clearMask = (bus.wr && bus.addr == stpd_pkg::OFS_CLEAR) ?
                       bus.wdata[stpd_pkg::NUM_EVT-1:0] : '0;

    always_comb begin
        rdata_nxt = '0;
        case (bus.addr)
            stpd_pkg::OFS_STATUS: rdata_nxt[stpd_pkg::NUM_EVT-1:0] = status_r;
            stpd_pkg::OFS_ENABLE: rdata_nxt[stpd_pkg::NUM_EVT-1:0] = enable_r;
            stpd_pkg::OFS_STATE: rdata_nxt[3:0] = {expired, levelValid, state_r};
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            idle_r <= '0;
            holdLast_r <= 1'b0;
            wake_r <= '0;
            state_r <= stpd_pkg::ST_ACTIVE;
            validLast_r <= 1'b0;
            status_r <= '0;
            enable_r <= stpd_pkg::ENABLE_RST;
            rdata <= '0;
        end else begin
            idle_r <= idle_nxt;
            holdLast_r <= hold_awake_in;
            wake_r <= wake_nxt;
            state_r <= state_nxt;
            validLast_r <= levelValid;
            status_r <= (status_r & ~clearMask) | events;
            if (bus.wr && bus.addr == stpd_pkg::OFS_ENABLE) begin
                enable_r <= bus.wdata[stpd_pkg::NUM_EVT-1:0];
            end
            rdata <= bus.rd ? rdata_nxt : '0;
        end
    end

    assign pumpOn = active;
    assign txOe_b = !active;
    assign rxOe_b = 1'b0;
    assign irq = |(status_r & enable_r);

    a_kill_forces_down: assert property (@(posedge clock) disable iff (!rst_b)
        !power_kill_n_in && active |=> !active)
        else $error("Power-kill did not force powerdown.");
    a_auto_gate: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(pumpOn) |-> $past(!power_kill_n_in || (!hold_awake_in && expired)))
        else $error("Powerdown without a valid cause.");
    a_down_stays: assert property (@(posedge clock) disable iff (!rst_b)
        state_r == stpd_pkg::ST_DOWN && !wakeReq |=> state_r == stpd_pkg::ST_DOWN)
        else $error("Left powerdown without a wake cause.");
    a_edge_wakes: assert property (@(posedge clock) disable iff (!rst_b)
        state_r == stpd_pkg::ST_DOWN && power_kill_n_in && lineEdge
        |=> state_r == stpd_pkg::ST_WAKING)
        else $error("Transition did not start wake.");
    a_tx_tristate: assert property (@(posedge clock) disable iff (!rst_b)
        !active |-> txOe_b && !rxOe_b)
        else $error("Output enables wrong in powerdown.");
    a_hold_resets_idle: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(hold_awake_in) |-> idle_r == '0)
        else $error("Idle timer not fresh after hold-awake fall.");
    a_wake_short: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(pumpOn) |-> $past(state_r) == stpd_pkg::ST_WAKING)
        else $error("Power-up skipped the wake delay.");
    a_sticky_irq: assert property (@(posedge clock) disable iff (!rst_b)
        events[0] && enable_r[0] |=> irq)
        else $error("Enabled event did not raise interrupt.");
    c_auto_down: cover property (@(posedge clock) disable iff (!rst_b)
        active && autoEn && expired ##1 !active);
    c_kill_down: cover property (@(posedge clock) disable iff (!rst_b)
        active && !power_kill_n_in ##1 !active);
    c_wake: cover property (@(posedge clock) disable iff (!rst_b) $rose(pumpOn));
    c_flag_rise: cover property (@(posedge clock) disable iff (!rst_b) $rose(levelValid));
endmodule : stpd_power_ctrl
`default_nettype wire

//--- common/stpd_pkg.sv
// Constants and carrier types for the serial transceiver powerdown controller.
// Assumes a single 125 MHz reference clock.
package stpd_pkg;
    localparam int CLK_MHZ = 125;
    localparam int NUM_TX = 3;
    localparam int NUM_RX = 5;
    localparam int NUM_EVT = 3;
    // Invalid-level window, valid-level delay and wake delay in microseconds.
    localparam int INVALID_US = 30;
    localparam int VALID_US = 1;
    localparam int WAKE_US = 100;
    // Inactivity window in seconds.
    localparam int IDLE_S = 30;
    localparam int INVALID_CYC = INVALID_US * CLK_MHZ + 1;
    localparam int VALID_CYC = VALID_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam longint IDLE_CYC = longint'(IDLE_S) * 1000000 * CLK_MHZ;
    localparam int CNT_W = 32;
    // Interrupt and state register offsets.
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CLEAR = 4'h4;
    localparam logic [3:0] OFS_ENABLE = 4'h8;
    localparam logic [3:0] OFS_STATE = 4'hc;
    // Event bit positions.
    localparam int EVT_POWER_DOWN = 0;
    localparam int EVT_POWER_UP = 1;
    localparam int EVT_VALID_CHG = 2;
    localparam logic [NUM_EVT-1:0] ENABLE_RST = 3'h0;

    typedef enum logic [1:0] {ST_ACTIVE, ST_DOWN, ST_WAKING} stpd_state_t;

    typedef struct packed {
        logic [NUM_TX-1:0] txIn;
        logic [NUM_RX-1:0] rxLevelValid;
        logic [NUM_RX-1:0] rxIn;
    } stpd_line_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } stpd_bus_t;
endpackage : stpd_pkg

//--- hw/stpd_level_det.sv
// Level-valid detector: flag falls after a long invalid window, rises soon after a valid level.
// Assumes inputs already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module stpd_level_det (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [stpd_pkg::NUM_RX-1:0] rxLevelValid,
    output logic levelValid
);
    logic anyValid;
    logic [stpd_pkg::CNT_W-1:0] cnt_r;
    logic [stpd_pkg::CNT_W-1:0] cnt_nxt;
    logic flag_r;
    logic flag_nxt;
    logic done;
    // Consecutive cycles with a valid level while the flag is still low.
    logic [7:0] riseRun_r;

    assign anyValid = |rxLevelValid;
    assign done = flag_r ? (cnt_r >= stpd_pkg::CNT_W'(stpd_pkg::INVALID_CYC - 1))
                         : (cnt_r >= stpd_pkg::CNT_W'(stpd_pkg::VALID_CYC - 1));
    // Counter runs while the input disagrees with the flag, and restarts otherwise.
    assign cnt_nxt = ((anyValid != flag_r) && !done) ? cnt_r + 1'b1 : '0;
    assign flag_nxt = ((anyValid != flag_r) && done) ? anyValid : flag_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            flag_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end
    assign levelValid = flag_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            riseRun_r <= '0;
        end else begin
            riseRun_r <= (!flag_r && anyValid) ? riseRun_r + 8'h01 : 8'h00;
        end
    end

    a_flag_falls: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(flag_r) |-> $past(!anyValid, 1))
        else $error("Flag fell without invalid level.");
    a_flag_rises: assert property (@(posedge clock) disable iff (!rst_b)
        riseRun_r <= 8'(stpd_pkg::VALID_CYC))
        else $error("Flag did not rise after valid level.");
endmodule : stpd_level_det
`default_nettype wire

//--- hw/stpd_edge_det.sv
// Two-stage synchroniser and edge detector for a bus of monitored inputs.
// Assumes asynchronous inputs from the line side.
`timescale 1ns/1ps
`default_nettype none
module stpd_edge_det #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic anyEdge
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] last_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end
    assign anyEdge = |(sync_r ^ last_r);
endmodule : stpd_edge_det
`default_nettype wire

//--- testbench/stpd_host_model.sv
// Host power manager model that drives the two force inputs.
// Assumes mode 0 manual, 1 flag to both inputs, 2 flag to kill with hold low.
`timescale 1ns/1ps
`default_nettype none
module stpd_host_model (
    input wire logic clock,
    input wire logic [1:0] mode,
    input wire logic holdReq,
    input wire logic killReq_b,
    input wire logic levelValid,
    output logic hold_awake_in,
    output logic power_kill_n_in
);
    initial begin
        hold_awake_in = 1'b1;
        power_kill_n_in = 1'b1;
    end
    always @(posedge clock) begin
        hold_awake_in <= (mode == 2'h0) ? holdReq : (mode == 2'h1) && levelValid;
        power_kill_n_in <= (mode == 2'h0) ? killReq_b : levelValid;
    end
endmodule : stpd_host_model
`default_nettype wire

//--- testbench/serial_transceiver_powerdown_ctrl_test.sv
// Self-checking bench for the powerdown controller with a host model on the force inputs.
// Assumes shortened idle and wake counts handed in as parameters.
`timescale 1ns/1ps
`default_nettype none
module serial_transceiver_powerdown_ctrl_test;
    localparam longint IDLE = 200;
    localparam int WAKE = 20;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    stpd_pkg::stpd_line_t line = '0;
    stpd_pkg::stpd_bus_t bus = '0;
    logic [1:0] mode = 2'h0;
    logic holdReq = 1'b1;
    logic killReq_b = 1'b1;
    logic holdIn, killIn_b, levelValid, pumpOn, txOe_b, rxOe_b, irq;
    logic [31:0] rdata;
    logic [31:0] d;
    int errors = 0;
    int numChecks = 0;
    int cycles = 0;

    stpd_power_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) i_stpd_power_ctrl (
        .clock(clock), .rst_b(rst_b), .line(line), .hold_awake_in(holdIn),
        .power_kill_n_in(killIn_b), .bus(bus), .rdata(rdata), .levelValid(levelValid),
        .pumpOn(pumpOn), .txOe_b(txOe_b), .rxOe_b(rxOe_b), .irq(irq));
    stpd_host_model i_stpd_host_model (.clock(clock), .mode(mode), .holdReq(holdReq),
        .killReq_b(killReq_b), .levelValid(levelValid), .hold_awake_in(holdIn),
        .power_kill_n_in(killIn_b));

    initial begin
        forever #4 clock = ~clock;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // Waits a bounded number of cycles for the pump state, then compares it.
    task automatic waitPump(input logic exp, input int n);
        int k;
        k = 0;
        while (pumpOn !== exp && k < n) begin
            @(posedge clock);
            #1;
            k++;
        end
        check("pumpOn", 32'(exp), 32'(pumpOn));
    endtask : waitPump
    task automatic toggleTx;
        @(posedge clock);
        line.txIn[0] <= ~line.txIn[0];
    endtask : toggleTx
    task automatic setValid(input logic [4:0] v);
        @(posedge clock);
        line.rxLevelValid <= v;
    endtask : setValid

    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        cyc(1);
        check("pumpOn", 32'h1, 32'(pumpOn));
        check("levelValid", 32'h0, 32'(levelValid));
        rd(stpd_pkg::OFS_ENABLE, d);
        check("enable", 32'(stpd_pkg::ENABLE_RST), d);
        wr(stpd_pkg::OFS_ENABLE, 32'h7);
        setValid(5'h10);
        cyc(120);
        check("levelValid", 32'h0, 32'(levelValid));
        cyc(10);
        check("levelValid", 32'h1, 32'(levelValid));
        setValid(5'h00);
        cyc(3740);
        check("levelValid", 32'h1, 32'(levelValid));
        cyc(20);
        check("levelValid", 32'h0, 32'(levelValid));
        check("pumpOn", 32'h1, 32'(pumpOn));
        $display("test level flag done");
        @(posedge clock);
        killReq_b <= 1'b0;
        waitPump(1'b0, 10);
        check("txOe_b", 32'h1, 32'(txOe_b));
        check("rxOe_b", 32'h0, 32'(rxOe_b));
        check("irq", 32'h1, 32'(irq));
        rd(stpd_pkg::OFS_STATUS, d);
        check("status", 32'h5, d & 32'h5);
        wr(stpd_pkg::OFS_CLEAR, 32'h7);
        rd(stpd_pkg::OFS_STATUS, d);
        check("status", 32'h0, d);
        check("irq", 32'h0, 32'(irq));
        setValid(5'h01);
        cyc(130);
        check("levelValid", 32'h1, 32'(levelValid));
        @(posedge clock);
        killReq_b <= 1'b1;
        cyc(WAKE - 5);
        check("pumpOn", 32'h0, 32'(pumpOn));
        waitPump(1'b1, 20);
        $display("test manual powerdown done");
        @(posedge clock);
        holdReq <= 1'b0;
        cyc(int'(IDLE) - 50);
        check("pumpOn", 32'h1, 32'(pumpOn));
        waitPump(1'b0, 100);
        cyc(300);
        check("pumpOn", 32'h0, 32'(pumpOn));
        toggleTx();
        waitPump(1'b1, WAKE + 10);
        $display("test automatic powerdown done");
        @(posedge clock);
        mode <= 2'h1;
        setValid(5'h00);
        waitPump(1'b0, 3800);
        setValid(5'h04);
        waitPump(1'b1, 180);
        @(posedge clock);
        mode <= 2'h2;
        setValid(5'h00);
        waitPump(1'b0, 3800);
        setValid(5'h02);
        cyc(200);
        check("pumpOn", 32'h0, 32'(pumpOn));
        toggleTx();
        waitPump(1'b1, WAKE + 10);
        $display("test flag wiring done");
        end_sim();
    end
endmodule : serial_transceiver_powerdown_ctrl_test
`default_nettype wire
